// *** core_cfg_pkg.sv ***
package core_cfg_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] CFG_OFFSET = 8'h3B;
   localparam logic [7:0] MASK_OFFSET = 8'h3C;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   // writable bits; everything else is reserved
   localparam logic [7:0] CFG_WRITE_MASK = 8'hE3;
   localparam logic [7:0] MASK_WRITE_MASK = 8'h17;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int OSC_ON_BIT = 7;
   localparam int CLK_SEL_LSB = 5;
   localparam int RETRIG_BIT = 1;
   localparam int RST_IGNORE_BIT = 0;
   localparam int LOGIC_EN_BIT = 4;
   localparam int OVERRUN_EN_BIT = 2;
   localparam int GPI_EN_BIT = 1;
   localparam int EVENT_EN_BIT = 0;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int REF_CLK_HZ = 100_000_000;
   localparam int OSC_HZ = 1_000_000;
   localparam int BASE_DIV = REF_CLK_HZ / OSC_HZ;
   localparam int RETRIG_TIME_US = 50;
   localparam int RETRIG_CYCLES = RETRIG_TIME_US * (REF_CLK_HZ / 1_000_000);
   // base ticks per core tick for 50, 100, 200, 500 kHz
   localparam logic [4:0] CORE_DIV_50K = 5'h14;
   localparam logic [4:0] CORE_DIV_100K = 5'h0A;
   localparam logic [4:0] CORE_DIV_200K = 5'h05;
   localparam logic [4:0] CORE_DIV_500K = 5'h02;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic logic_block;
      logic fifo_overrun;
      logic general_input;
      logic fifo_event;
   } status_flags_t;

   typedef enum {IRQ_IDLE, IRQ_ASSERTED, IRQ_GAP} irq_state_t;

endpackage : core_cfg_pkg

// *** core_clock_and_irq_config.sv ***
// Operation
// R1: internal 1 MHz oscillator runs only while oscillator_on is set.
// R2: core clock select 00/01/10/11 gives 50/100/200/500 kHz.
// R3: key and input scan intervals follow the selected core clock.
// R4: retrigger off: clear with interrupt pending keeps interrupt asserted.
// R5: retrigger on: clear with pending releases interrupt 50 us, reasserts.
// R6: reset pin low resets device unless the reset-ignore bit is set.
// R7: logic-block flag reaches interrupt only with its enable bit 4.
// R8: FIFO-overrun flag reaches interrupt only with its enable bit 2.
// R9: general-input flag reaches interrupt only with its enable bit 1.
// R10: FIFO-event flag reaches interrupt only with its enable bit 0.
// R11: interrupt asserted while any enabled flag set, else released.
// R12: reserved bits read zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none
module core_clock_and_irq_config #(
   parameter int RETRIG_CYCLES = core_cfg_pkg::RETRIG_CYCLES
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire core_cfg_pkg::reg_req_t reg_req_in,
   input wire core_cfg_pkg::status_flags_t status_flags_in,
   input wire logic irq_clear_in,
   input wire logic reset_pin_n_in,
   output logic [7:0] reg_rdata_out,
   output logic irq_n_out,
   output logic irq_oe_out,
   output logic device_reset_out,
   output logic osc_running_out,
   output logic base_tick_out,
   output logic core_tick_out,
   output logic scan_tick_out
);

   localparam int GAP_W = $clog2(RETRIG_CYCLES + 1);
   localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(RETRIG_CYCLES - 1);

   logic [7:0] cfg_reg;
   logic [7:0] cfg_next;
   logic [7:0] mask_reg;
   logic [7:0] mask_next;
   logic pin_meta_reg;
   logic pin_sync_reg;
   logic dev_reset_reg;
   logic [GAP_W-1:0] gap_cnt_reg;
   logic [GAP_W-1:0] gap_cnt_next;
   core_cfg_pkg::irq_state_t irq_state_reg;
   core_cfg_pkg::irq_state_t irq_state_next;

   wire cfg_hit;
   wire mask_hit;
   wire [7:0] rdata_next;
   wire oscillator_on;
   wire [1:0] core_clock_select;
   wire retrigger_mode;
   wire reset_ignore;
   wire logic_block_irq_enable;
   wire fifo_overrun_irq_enable;
   wire general_input_irq_enable;
   wire fifo_event_irq_enable;
   wire [3:0] gated_flags;
   wire irq_pending;
   wire dev_reset_next;
   wire gap_done;
   wire core_tick;

   // ------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------
   assign cfg_hit = reg_req_in.addr == core_cfg_pkg::CFG_OFFSET;
   assign mask_hit = reg_req_in.addr == core_cfg_pkg::MASK_OFFSET;
   // R12: reserved bits masked on write
   assign cfg_next = (reg_req_in.wr && cfg_hit) ?
                     (reg_req_in.wdata & core_cfg_pkg::CFG_WRITE_MASK) :
                     cfg_reg;
   assign mask_next = (reg_req_in.wr && mask_hit) ?
                      (reg_req_in.wdata & core_cfg_pkg::MASK_WRITE_MASK) :
                      mask_reg;
   // unmapped addresses read zero
   assign rdata_next = cfg_hit ? cfg_reg :
                       mask_hit ? mask_reg : 8'h00;

   assign oscillator_on = cfg_reg[core_cfg_pkg::OSC_ON_BIT];
   assign core_clock_select =
      cfg_reg[core_cfg_pkg::CLK_SEL_LSB +: 2];
   assign retrigger_mode = cfg_reg[core_cfg_pkg::RETRIG_BIT];
   assign reset_ignore = cfg_reg[core_cfg_pkg::RST_IGNORE_BIT];
   assign logic_block_irq_enable = mask_reg[core_cfg_pkg::LOGIC_EN_BIT];
   assign fifo_overrun_irq_enable = mask_reg[core_cfg_pkg::OVERRUN_EN_BIT];
   assign general_input_irq_enable = mask_reg[core_cfg_pkg::GPI_EN_BIT];
   assign fifo_event_irq_enable = mask_reg[core_cfg_pkg::EVENT_EN_BIT];

   // ------------------------------------------------------------
   // source gating
   // ------------------------------------------------------------
   // R7: logic-block gate
   assign gated_flags[3] =
      status_flags_in.logic_block & logic_block_irq_enable;
   // R8: overrun gate
   assign gated_flags[2] =
      status_flags_in.fifo_overrun & fifo_overrun_irq_enable;
   // R9: general-input gate
   assign gated_flags[1] =
      status_flags_in.general_input & general_input_irq_enable;
   // R10: fifo-event gate
   assign gated_flags[0] =
      status_flags_in.fifo_event & fifo_event_irq_enable;
   // R11: any enabled source
   assign irq_pending = |gated_flags;

   // ------------------------------------------------------------
   // external reset pin
   // ------------------------------------------------------------
   // R6: pin honoured unless ignored
   assign dev_reset_next = !pin_sync_reg && !reset_ignore;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_meta_reg <= 1'b1;
         pin_sync_reg <= 1'b1;
         dev_reset_reg <= 1'b0;
      end else begin
         pin_meta_reg <= reset_pin_n_in;
         pin_sync_reg <= pin_meta_reg;
         dev_reset_reg <= dev_reset_next;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // pin reset returns config to defaults; ignore bit then reads 0 anyway
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_reg <= core_cfg_pkg::CFG_RESET;
         mask_reg <= core_cfg_pkg::MASK_RESET;
         reg_rdata_out <= 8'h00;
      end else if (dev_reset_reg) begin
         cfg_reg <= core_cfg_pkg::CFG_RESET;
         mask_reg <= core_cfg_pkg::MASK_RESET;
         reg_rdata_out <= 8'h00;
      end else begin
         cfg_reg <= cfg_next;
         mask_reg <= mask_next;
         reg_rdata_out <= rdata_next;
      end
   end

   // ------------------------------------------------------------
   // core clock
   // ------------------------------------------------------------
   core_clock_divider u_divider (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .sync_clear_in(dev_reset_reg),
      .osc_on_in(oscillator_on),
      .core_sel_in(core_clock_select),
      .base_tick_out(base_tick_out),
      .core_tick_out(core_tick)
   );
   assign core_tick_out = core_tick;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         osc_running_out <= 1'b0;
         scan_tick_out <= 1'b0;
      end else if (dev_reset_reg) begin
         // pin reset drops the running flag at once; scan keeps its lag
         osc_running_out <= 1'b0;
         scan_tick_out <= core_tick;
      end else begin
         osc_running_out <= oscillator_on;
         // R3: scanning paced by core clock
         scan_tick_out <= core_tick;
      end
   end

   // ------------------------------------------------------------
   // interrupt output
   // ------------------------------------------------------------
   assign gap_done = gap_cnt_reg == GAP_LAST;

   always_comb begin
      irq_state_next = irq_state_reg;
      gap_cnt_next = gap_cnt_reg;
      case (irq_state_reg)
         core_cfg_pkg::IRQ_IDLE: begin
            gap_cnt_next = '0;
            // R11: assert on pending
            if (irq_pending) begin
               irq_state_next = core_cfg_pkg::IRQ_ASSERTED;
            end
         end
         core_cfg_pkg::IRQ_ASSERTED: begin
            gap_cnt_next = '0;
            if (!irq_pending) begin
               irq_state_next = core_cfg_pkg::IRQ_IDLE;
            // R5: release gap on clear
            end else if (irq_clear_in && retrigger_mode) begin
               irq_state_next = core_cfg_pkg::IRQ_GAP;
            end
            // R4: otherwise stays asserted
         end
         core_cfg_pkg::IRQ_GAP: begin
            gap_cnt_next = gap_cnt_reg + GAP_W'(1);
            // R5: reassert after gap
            if (gap_done) begin
               gap_cnt_next = '0;
               irq_state_next = irq_pending ? core_cfg_pkg::IRQ_ASSERTED :
                                              core_cfg_pkg::IRQ_IDLE;
            end
         end
         default: begin
            irq_state_next = core_cfg_pkg::IRQ_IDLE;
            gap_cnt_next = '0;
         end
      endcase
   end

   // open drain: drive low only while asserted
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_state_reg <= core_cfg_pkg::IRQ_IDLE;
         gap_cnt_reg <= '0;
         irq_n_out <= 1'b1;
         irq_oe_out <= 1'b0;
      end else if (dev_reset_reg) begin
         irq_state_reg <= core_cfg_pkg::IRQ_IDLE;
         gap_cnt_reg <= '0;
         irq_n_out <= 1'b1;
         irq_oe_out <= 1'b0;
      end else begin
         irq_state_reg <= irq_state_next;
         gap_cnt_reg <= gap_cnt_next;
         irq_n_out <= irq_state_next != core_cfg_pkg::IRQ_ASSERTED;
         irq_oe_out <= irq_state_next == core_cfg_pkg::IRQ_ASSERTED;
      end
   end

   assign device_reset_out = dev_reset_reg;

endmodule : core_clock_and_irq_config
`default_nettype wire

// *** core_clock_and_irq_config_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module irq_cfg_checker #(
   parameter int RETRIG_CYCLES = 8
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire core_cfg_pkg::reg_req_t reg_req_in,
   input wire core_cfg_pkg::status_flags_t status_flags_in,
   input wire logic irq_clear_in,
   input wire logic reset_pin_n_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic irq_n_out,
   input wire logic irq_oe_out,
   input wire logic device_reset_out,
   input wire logic osc_running_out,
   input wire logic base_tick_out,
   input wire logic core_tick_out,
   input wire logic scan_tick_out
);
   // ------------------------------------------------------------
   // port relations
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   chk_oe_inverse: assert property (irq_oe_out == !irq_n_out)
      else $error("oe not inverse of irq");
   chk_idle_release: assert property (
      status_flags_in == 4'h0 |=> irq_n_out)
      else $error("irq asserted with no flags");
   // gap length fixed by the bench's RETRIG_CYCLES of 8
   chk_retrig_gap: assert property (
      $rose(irq_n_out) && $past(irq_clear_in) |-> irq_n_out [*8])
      else $error("retrigger gap too short");
   chk_osc_quiet: assert property (
      !osc_running_out && !$past(osc_running_out) |-> !base_tick_out)
      else $error("base tick with oscillator off");
   chk_base_spacing: assert property (
      base_tick_out |=> !base_tick_out [*8])
      else $error("base ticks too close");
   chk_core_spacing: assert property (
      core_tick_out |=> !core_tick_out [*8])
      else $error("core ticks too close");
   chk_scan_pacing: assert property (
      scan_tick_out == $past(core_tick_out))
      else $error("scan tick not one after core tick");
   chk_pin_cause: assert property (
      $rose(device_reset_out) |-> !$past(reset_pin_n_in, 3))
      else $error("device reset without pin low");
   chk_pin_hold: assert property (
      device_reset_out && $past(device_reset_out)
      |-> irq_n_out && !osc_running_out && reg_rdata_out == 8'h00)
      else $error("state not held during pin reset");
   chk_reserved_zero: assert property (
      (reg_rdata_out & ($past(reg_req_in.addr) == 8'h3B ? 8'h1C :
      $past(reg_req_in.addr) == 8'h3C ? 8'hE8 : 8'hFF)) == 8'h00)
      else $error("reserved or unmapped bits read nonzero");
endmodule : irq_cfg_checker
bind core_clock_and_irq_config irq_cfg_checker #(
   .RETRIG_CYCLES(RETRIG_CYCLES)) u_chk (.*);
`default_nettype wire

// *** core_clock_and_irq_config_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module core_clock_and_irq_config_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic pin_n = 1'b1;
   core_cfg_pkg::status_flags_t flags = '0;
   core_cfg_pkg::reg_req_t req;
   logic clr, irq_n, irq_oe, dev_rst, osc_run, base_t, core_t, scan_t;
   logic [7:0] rdata, got;
   logic [31:0] seed = 32'h4;
   int n_errors = 0;
   int n_tests = 0;
   int cfg_m = 0;
   int mask_m = 0;
   int n;
   int divs[4] = '{20, 10, 5, 2};
   always #5 clk = ~clk;
   core_clock_and_irq_config #(.RETRIG_CYCLES(8)) dut (
      .ref_clk_in(clk), .rst_n_in(rst_n), .reg_req_in(req),
      .status_flags_in(flags), .irq_clear_in(clr),
      .reset_pin_n_in(pin_n), .reg_rdata_out(rdata), .irq_n_out(irq_n),
      .irq_oe_out(irq_oe), .device_reset_out(dev_rst),
      .osc_running_out(osc_run), .base_tick_out(base_t),
      .core_tick_out(core_t), .scan_tick_out(scan_t));
   host_model host (.ref_clk_in(clk), .reg_rdata_in(rdata),
      .reg_req_out(req), .irq_clear_out(clr));
   // ------------------------------------------------------------
   // reference model and helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [31:0] exp_irq();
      int f;
      f = int'(flags);
      return ((f >> 3) & (mask_m >> 4) & 1) | (f & mask_m & 7) ? 0 : 1;
   endfunction : exp_irq
   task automatic check(input string s, input logic [31:0] seen,
         input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %0h seen %0h", s, exp, seen);
      end
   endtask : check
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      host.write_reg(a, d);
      if (a == 8'h3B) cfg_m = d & 8'hE3;
      if (a == 8'h3C) mask_m = d & 8'h17;
   endtask : w
   task automatic rd(input logic [7:0] a);
      host.read_reg(a, got);
      check("rdata", got, a == 8'h3B ? cfg_m : a == 8'h3C ? mask_m : 0);
   endtask : rd
   task automatic gap();
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (core_t !== 1'b1 && n < 5000);
   endtask : gap
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      conclude();
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      rd(8'h3B);
      w(8'h3D, 8'hFF);
      w(8'h3C, 8'hFF);
      rd(8'h3C);
      rd(8'h3D);
      for (int i = 0; i < 24; i++) begin
         w(8'h3C, 8'(rnd()));
         flags = 4'(rnd());
         repeat (2) @(negedge clk);
         check("irq_n", irq_n, exp_irq());
      end
      w(8'h3C, 8'h01);
      flags = 4'h1;
      host.clear_irq();
      check("irq_n", irq_n, 0);
      check("irq_oe", irq_oe, 1);
      w(8'h3B, 8'hFE);
      rd(8'h3B);
      host.clear_irq();
      for (int k = 0; k < 8; k++) begin
         check("gap", irq_n, 1);
         @(negedge clk);
      end
      check("irq_n", irq_n, 0);
      flags = 4'h0;
      w(8'h3B, 8'h00);
      n = 0;
      repeat (300) @(negedge clk) n += base_t;
      check("base", n, 0);
      check("osc_run", osc_run, 0);
      for (int s = 0; s < 4; s++) begin
         w(8'h3B, 8'(8'h80 | (s << 5)));
         repeat (3) gap();
         check("period", n, 100 * divs[s]);
         check("osc_run", osc_run, 1);
         @(negedge clk);
         check("scan", scan_t, 1);
      end
      w(8'h3B, 8'h01);
      @(negedge clk) pin_n = 1'b0;
      repeat (5) @(negedge clk);
      check("dev_rst", dev_rst, 0);
      w(8'h3B, 8'h80);
      repeat (5) @(negedge clk);
      check("dev_rst", dev_rst, 1);
      check("osc_run", osc_run, 0);
      cfg_m = 0;
      mask_m = 0;
      pin_n = 1'b1;
      repeat (5) @(negedge clk);
      rd(8'h3B);
      rd(8'h3C);
      conclude();
   end
endmodule : core_clock_and_irq_config_tb
`default_nettype wire

// *** core_clock_divider.sv ***
`timescale 1ns/10ps
`default_nettype none
module core_clock_divider (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic sync_clear_in,
   input wire logic osc_on_in,
   input wire logic [1:0] core_sel_in,
   output logic base_tick_out,
   output logic core_tick_out
);

   localparam logic [6:0] BASE_LAST =
      7'(core_cfg_pkg::BASE_DIV - 1);

   logic [6:0] base_cnt_reg;
   logic [6:0] base_cnt_next;
   logic [4:0] core_cnt_reg;
   logic [4:0] core_cnt_next;
   logic [4:0] core_div;
   logic base_wrap;
   logic core_wrap;

   // ------------------------------------------------------------
   // divider selection
   // ------------------------------------------------------------
   // R2: core rate select
   assign core_div = (core_sel_in == 2'h0) ? core_cfg_pkg::CORE_DIV_50K :
                     (core_sel_in == 2'h1) ? core_cfg_pkg::CORE_DIV_100K :
                     (core_sel_in == 2'h2) ? core_cfg_pkg::CORE_DIV_200K :
                                             core_cfg_pkg::CORE_DIV_500K;
   // R1: oscillator runs only when on
   assign base_wrap = osc_on_in && (base_cnt_reg == BASE_LAST);
   assign core_wrap = base_wrap && (core_cnt_reg >= core_div - 5'h01);
   assign base_cnt_next = !osc_on_in ? 7'h00 :
                          base_wrap ? 7'h00 : base_cnt_reg + 7'h01;
   // rate change applies to the period in progress; a count already past the new limit wraps at the next base tick
   assign core_cnt_next = !osc_on_in ? 5'h00 :
                          core_wrap ? 5'h00 :
                          base_wrap ? core_cnt_reg + 5'h01 : core_cnt_reg;

   // ------------------------------------------------------------
   // counters
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         base_cnt_reg <= 7'h00;
         core_cnt_reg <= 5'h00;
         base_tick_out <= 1'b0;
         core_tick_out <= 1'b0;
      end else if (sync_clear_in) begin
         base_cnt_reg <= 7'h00;
         core_cnt_reg <= 5'h00;
         base_tick_out <= 1'b0;
         core_tick_out <= 1'b0;
      end else begin
         base_cnt_reg <= base_cnt_next;
         core_cnt_reg <= core_cnt_next;
         base_tick_out <= base_wrap;
         core_tick_out <= core_wrap;
      end
   end

endmodule : core_clock_divider
`default_nettype wire

// *** host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input wire logic ref_clk_in,
   input wire logic [7:0] reg_rdata_in,
   output var core_cfg_pkg::reg_req_t reg_req_out,
   output logic irq_clear_out
);
   initial begin
      reg_req_out = '0;
      irq_clear_out = 1'b0;
   end
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_in);
      reg_req_out = {1'b1, a, d};
      @(negedge ref_clk_in);
      reg_req_out.wr = 1'b0;
   endtask : write_reg
   // released data lines flip so stale values never look valid
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk_in);
      reg_req_out = {1'b0, a, ~reg_req_out.wdata};
      @(negedge ref_clk_in);
      d = reg_rdata_in;
   endtask : read_reg
   task automatic clear_irq();
      @(negedge ref_clk_in);
      irq_clear_out = 1'b1;
      @(negedge ref_clk_in);
      irq_clear_out = 1'b0;
   endtask : clear_irq
endmodule : host_model
`default_nettype wire
